// [rtl/tfhp_pkg.sv]
package tfhp_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_NS = 100;
  localparam int PRESENT_CHECK_MS = 4;
  localparam real POR_SLV_HOLD_S = 14.0;
  localparam real POR_MST_WAIT_S = 14.5;
  localparam int SRST_SLV_HOLD_MS = 400;
  localparam int SRST_MST_WAIT_MS = 450;
  localparam int SLV_PRESENT_S = 31;
  localparam int RW_PULSE_NS = 75;
  localparam int PRESENT_CHECK_CYC = PRESENT_CHECK_MS * (CLK_HZ / 1000);
  localparam int POR_SLV_HOLD_CYC = $rtoi(POR_SLV_HOLD_S * CLK_HZ);
  localparam int POR_MST_WAIT_CYC = $rtoi(POR_MST_WAIT_S * CLK_HZ);
  localparam int SRST_SLV_HOLD_CYC = SRST_SLV_HOLD_MS * (CLK_HZ / 1000);
  localparam int SRST_MST_WAIT_CYC = SRST_MST_WAIT_MS * (CLK_HZ / 1000);
  localparam int SLV_PRESENT_CYC = SLV_PRESENT_S * CLK_HZ;
  localparam int RW_PULSE_CYC = (RW_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOST_RST_HOLD_CYC = 16;
  localparam int TMR_W = 32;
  // ----------------------------------------------------------------
  // Task-file register indices and fields
  // ----------------------------------------------------------------
  localparam logic [2:0] IDX_DATA = 3'h0;
  localparam logic [2:0] IDX_ERROR = 3'h1;
  localparam logic [2:0] IDX_SDH = 3'h6;
  localparam logic [2:0] IDX_STATCMD = 3'h7;
  localparam logic [2:0] IDX_ALTDOR = 3'h6;
  localparam logic [2:0] IDX_DRVADDR = 3'h7;
  localparam int SDH_DRV_BIT = 4;
  localparam int DOR_NIEN_BIT = 1;
  localparam int DOR_SRST_BIT = 2;
  localparam int ST_BSY_BIT = 7;
  localparam int ST_DRDY_BIT = 6;
  localparam int ST_DSC_BIT = 4;
  localparam logic [7:0] DOR_RESET = 8'h00;
  // ----------------------------------------------------------------
  // Host adapter register map (Avalon byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] AV_CTRL = 4'h0;
  localparam logic [3:0] AV_RDATA = 4'h4;
  localparam logic [3:0] AV_PINS = 4'h8;
  localparam int CTL_IDX_LSB = 16;
  localparam int CTL_HIGH_BIT = 19;
  localparam int CTL_READ_BIT = 20;
  localparam int CTL_WORD_BIT = 21;
  localparam int CTL_W = 22;

  typedef enum logic [1:0] {PM_ACTIVITY, PM_SYNC, PM_FLOAT} tfhp_pinmode_t;
endpackage

// [rtl/tfhp_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface tfhp_if;
  logic resetLine_n;
  logic write_strobe_n;
  logic read_strobe_n;
  logic addrLatchEnable;
  logic [2:0] register_index_lines;
  logic low_select_n;
  logic high_select_n;
  logic [15:0] hostDataOut;
  logic hostOeLo_n;
  logic hostOeHi_n;
  logic [15:0] devDataOut;
  logic devOeLo_n;
  logic devOeHi_n;
  logic [15:0] dataBus;
  logic [7:0] low_data_byte;
  logic irqOut;
  logic irqOe_n;
  logic host_interrupt_out;
  logic widthAckOut;
  logic widthAckOe_n;
  logic word_width_ack_n;
  logic diagOut;
  logic diagOe_n;
  logic diag_handshake_n;
  logic slvActOut;
  logic slvActOe_n;
  logic slave_present_activity_n;

  // ----------------------------------------------------------------
  // Wire resolution; undriven lines float to their pulled level.
  // ----------------------------------------------------------------
  assign dataBus[7:0] = !devOeLo_n ? devDataOut[7:0] :
                        !hostOeLo_n ? hostDataOut[7:0] : 8'hFF;
  assign dataBus[15:8] = !devOeHi_n ? devDataOut[15:8] :
                         !hostOeHi_n ? hostDataOut[15:8] : 8'hFF;
  assign low_data_byte = dataBus[7:0];
  assign host_interrupt_out = !irqOe_n ? irqOut : 1'b0;
  assign word_width_ack_n = !widthAckOe_n ? widthAckOut : 1'b1;
  assign diag_handshake_n = !diagOe_n ? diagOut : 1'b1;
  assign slave_present_activity_n = !slvActOe_n ? slvActOut : 1'b1;

  modport drv_mp (
    input resetLine_n, write_strobe_n, read_strobe_n, addrLatchEnable,
    input register_index_lines, low_select_n, high_select_n, dataBus,
    input diag_handshake_n,
    output devDataOut, devOeLo_n, devOeHi_n, irqOut, irqOe_n,
    output widthAckOut, widthAckOe_n, diagOut, diagOe_n,
    output slvActOut, slvActOe_n
  );
  modport host_mp (
    output resetLine_n, write_strobe_n, read_strobe_n, addrLatchEnable,
    output register_index_lines, low_select_n, high_select_n,
    output hostDataOut, hostOeLo_n, hostOeHi_n,
    input dataBus, host_interrupt_out, word_width_ack_n,
    input diag_handshake_n, slave_present_activity_n
  );
endinterface
`default_nettype wire

// [rtl/tfhp_timer.sv]
`timescale 1ns/100ps
`default_nettype none
module tfhp_timer (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic start,
  input wire logic [tfhp_pkg::TMR_W-1:0] count,
  output logic done
);
  logic [tfhp_pkg::TMR_W-1:0] cnt_q;
  logic run_q;

  // Done fires in the count-th cycle after start; a restart wins.
  assign done = run_q && !start && (cnt_q == 32'h00000001);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (ce) begin
      if (start) begin
        cnt_q <= count;
        run_q <= 1'b1;
      end else if (run_q) begin
        cnt_q <= cnt_q - 32'h00000001;
        run_q <= !done;
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/tfhp_drive.sv]
`timescale 1ns/100ps
`default_nettype none
module tfhp_drive #(
  parameter int P_PRESENT_CHECK = tfhp_pkg::PRESENT_CHECK_CYC,
  parameter int P_POR_SLV_HOLD = tfhp_pkg::POR_SLV_HOLD_CYC,
  parameter int P_POR_MST_WAIT = tfhp_pkg::POR_MST_WAIT_CYC,
  parameter int P_SRST_SLV_HOLD = tfhp_pkg::SRST_SLV_HOLD_CYC,
  parameter int P_SRST_MST_WAIT = tfhp_pkg::SRST_MST_WAIT_CYC,
  parameter int P_SLV_PRESENT = tfhp_pkg::SLV_PRESENT_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  tfhp_if.drv_mp bus,
  input wire logic isSlave,
  input wire tfhp_pkg::tfhp_pinmode_t pinMode,
  input wire logic activity,
  input wire logic spindleSync,
  input wire logic spinReady,
  input wire logic driveReady,
  input wire logic diagRunning,
  input wire logic diagPassed,
  input wire logic [7:0] statusIn,
  input wire logic [7:0] errorIn,
  input wire logic irqSet,
  input wire logic wordReady,
  input wire logic [15:0] rdWord,
  output logic [15:0] wrWord_q,
  output logic wrWordStb_q,
  output logic rdWordStb_q,
  output logic [7:0] cmdByte_q,
  output logic cmdStb_q,
  output logic [7:0][7:0] taskFile_q,
  output logic busy_q,
  output logic slaveSeen_q
);
  typedef enum logic [2:0] {
    DG_SLV_HOLD, DG_MST_SEEK, DG_MST_WAIT, DG_DONE
  } tfhp_diag_t;

  // ----------------------------------------------------------------
  // Status shaping
  // ----------------------------------------------------------------
  function automatic logic [7:0] statusView(input logic [7:0] s,
                                            input logic busy,
                                            input logic spun);
    logic [7:0] v;
    v = s;
    if (!spun) begin
      v[tfhp_pkg::ST_DRDY_BIT] = 1'b0;
      v[tfhp_pkg::ST_DSC_BIT] = 1'b0;
    end
    if (busy) begin
      v[tfhp_pkg::ST_BSY_BIT] = 1'b1;
    end
    return v;
  endfunction

  logic wrN_q;
  logic rdN_q;
  logic [15:0] wdat_q;
  logic [15:0] rdData_q;
  logic [7:0] dor_q;
  logic irq_q;
  logic started_q;
  logic porKind_q;
  logic spPhase_q;
  tfhp_diag_t st_q;
  logic diagDone;
  logic spDone;

  // ----------------------------------------------------------------
  // Host port decode
  // ----------------------------------------------------------------
  // The address latch enable carries no meaning here and is left unread.
  wire logic [2:0] idx = bus.register_index_lines;
  wire logic lowSel = !bus.low_select_n && bus.high_select_n;
  wire logic highSel = bus.low_select_n && !bus.high_select_n;
  wire logic hiReadable = highSel && (idx[2:1] == 2'b11);
  wire logic drvSel =
    (taskFile_q[tfhp_pkg::IDX_SDH][tfhp_pkg::SDH_DRV_BIT] == isSlave);
  wire logic dataAddr = lowSel && (idx == tfhp_pkg::IDX_DATA);
  wire logic wrRise = !wrN_q && bus.write_strobe_n;
  wire logic rdRise = !rdN_q && bus.read_strobe_n;
  wire logic readHit = !bus.read_strobe_n && drvSel &&
                       (lowSel || hiReadable);
  wire logic statusRd = rdRise && drvSel && lowSel &&
                        (idx == tfhp_pkg::IDX_STATCMD);
  wire logic cmdWr = wrRise && drvSel && lowSel &&
                     (idx == tfhp_pkg::IDX_STATCMD);
  wire logic dorWr = wrRise && highSel && (idx == tfhp_pkg::IDX_ALTDOR);
  wire logic kickPor = !started_q || !bus.resetLine_n;
  wire logic kickSoft = dorWr && wdat_q[tfhp_pkg::DOR_SRST_BIT];
  wire logic kick = kickPor || kickSoft;

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------
  wire logic [7:0] statNow = statusView(statusIn, busy_q, spinReady);
  wire logic [7:0] drvAddrView = {4'hF, ~taskFile_q[tfhp_pkg::IDX_SDH][3:0]};
  wire logic [7:0] lowByte =
    (idx == tfhp_pkg::IDX_ERROR) ? errorIn :
    (idx == tfhp_pkg::IDX_STATCMD) ? statNow : taskFile_q[idx];
  wire logic [7:0] highByte =
    (idx == tfhp_pkg::IDX_DRVADDR) ? drvAddrView : statNow;
  wire logic [15:0] readView =
    dataAddr ? rdWord :
    lowSel ? {8'h00, lowByte} : {8'h00, highByte};

  assign bus.devDataOut = rdData_q;
  assign bus.devOeLo_n = !readHit;
  assign bus.devOeHi_n = !(readHit && dataAddr);
  assign bus.irqOut = irq_q;
  assign bus.irqOe_n = !(drvSel && !dor_q[tfhp_pkg::DOR_NIEN_BIT]);
  assign bus.widthAckOut = 1'b0;
  assign bus.widthAckOe_n = !(drvSel && dataAddr && wordReady);

  // ----------------------------------------------------------------
  // Strobe tracking and task-file writes
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wrN_q <= 1'b1;
      rdN_q <= 1'b1;
      wdat_q <= 16'h0000;
      rdData_q <= 16'h0000;
    end else if (ce) begin
      wrN_q <= bus.write_strobe_n;
      rdN_q <= bus.read_strobe_n;
      if (!bus.write_strobe_n) begin
        wdat_q <= bus.dataBus;
      end
      rdData_q <= readView;
    end
  end

  // Both drives take every task-file and control write; data-word and command writes are gated.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      taskFile_q <= '0;
      dor_q <= tfhp_pkg::DOR_RESET;
      wrWord_q <= 16'h0000;
      wrWordStb_q <= 1'b0;
      rdWordStb_q <= 1'b0;
      cmdByte_q <= 8'h00;
      cmdStb_q <= 1'b0;
    end else if (ce) begin
      wrWordStb_q <= wrRise && drvSel && dataAddr;
      rdWordStb_q <= rdRise && drvSel && dataAddr;
      cmdStb_q <= cmdWr;
      if (wrRise && lowSel && !dataAddr) begin
        taskFile_q[idx] <= wdat_q[7:0];
      end
      if (wrRise && drvSel && dataAddr) begin
        wrWord_q <= wdat_q;
      end
      if (cmdWr) begin
        cmdByte_q <= wdat_q[7:0];
      end
      if (dorWr) begin
        dor_q <= wdat_q[7:0];
      end
    end
  end

  // Set wins over a clear in the same cycle so no event is dropped.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else if (ce) begin
      irq_q <= irqSet || (irq_q && !statusRd && !cmdWr);
    end
  end

  // ----------------------------------------------------------------
  // Reset handshake sequencing
  // ----------------------------------------------------------------
  wire logic seekStart = kick && !isSlave;
  wire logic waitStart = (st_q == DG_MST_SEEK) && !kick &&
                         !bus.diag_handshake_n;
  wire logic [31:0] diagCount =
    waitStart ? (porKind_q ? 32'(P_POR_MST_WAIT) : 32'(P_SRST_MST_WAIT)) :
    seekStart ? 32'(P_PRESENT_CHECK) :
    kickPor ? 32'(P_POR_SLV_HOLD) : 32'(P_SRST_SLV_HOLD);

  tfhp_timer diagTimer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .start(kick || waitStart),
    .count(diagCount),
    .done(diagDone)
  );

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q <= DG_DONE;
      started_q <= 1'b0;
      porKind_q <= 1'b1;
      slaveSeen_q <= 1'b0;
    end else if (ce) begin
      started_q <= 1'b1;
      if (kick) begin
        porKind_q <= kickPor;
        st_q <= isSlave ? DG_SLV_HOLD : DG_MST_SEEK;
      end else begin
        case (st_q)
          DG_SLV_HOLD: begin
            if (driveReady || diagDone) begin
              st_q <= DG_DONE;
            end
          end
          DG_MST_SEEK: begin
            if (waitStart) begin
              slaveSeen_q <= 1'b1;
              st_q <= DG_MST_WAIT;
            end else if (diagDone) begin
              slaveSeen_q <= 1'b0;
              st_q <= DG_DONE;
            end
          end
          DG_MST_WAIT: begin
            if (bus.diag_handshake_n || diagDone) begin
              st_q <= DG_DONE;
            end
          end
          default: st_q <= DG_DONE;
        endcase
      end
    end
  end

  assign busy_q = (st_q != DG_DONE);

  // A slave holds the line low through its hold phase, then low again
  // only once its diagnostic has passed and is no longer running.
  assign bus.diagOut = 1'b0;
  assign bus.diagOe_n = !(isSlave && ((st_q == DG_SLV_HOLD) ||
    ((st_q == DG_DONE) && diagPassed && !diagRunning)));

  // ----------------------------------------------------------------
  // Multiplexed activity / slave-present pin
  // ----------------------------------------------------------------
  tfhp_timer presentTimer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .start(kick && isSlave),
    .count(32'(P_SLV_PRESENT)),
    .done(spDone)
  );

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      spPhase_q <= 1'b0;
    end else if (ce) begin
      if (kick && isSlave) begin
        spPhase_q <= 1'b1;
      end else if (cmdWr || spDone) begin
        spPhase_q <= 1'b0;
      end
    end
  end

  assign bus.slvActOut = spPhase_q ? 1'b0 :
    (pinMode == tfhp_pkg::PM_SYNC) ? spindleSync : !activity;
  assign bus.slvActOe_n = !(spPhase_q ||
    (pinMode != tfhp_pkg::PM_FLOAT));
endmodule
`default_nettype wire

// [rtl/tfhp_host.sv]
`timescale 1ns/100ps
`default_nettype none
module tfhp_host (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  tfhp_if.host_mp bus,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  typedef enum logic [1:0] {HS_IDLE, HS_SETUP, HS_STROBE, HS_HOLD} tfhp_hst_t;

  tfhp_hst_t st_q;
  logic [tfhp_pkg::CTL_W-1:0] ctrl_q;
  logic [3:0] pulse_q;
  logic [15:0] rdData_q;
  logic [4:0] rstCnt_q;
  logic rstDone_q;
  logic rdv_q;

  // ----------------------------------------------------------------
  // Avalon decode
  // ----------------------------------------------------------------
  wire logic ctrlWr = avs_write && (avs_address == tfhp_pkg::AV_CTRL);
  wire logic isRead = ctrl_q[tfhp_pkg::CTL_READ_BIT];
  wire logic isWord = ctrl_q[tfhp_pkg::CTL_WORD_BIT];
  wire logic isHigh = ctrl_q[tfhp_pkg::CTL_HIGH_BIT];
  wire logic active = (st_q != HS_IDLE);
  wire logic [31:0] pinView = {27'h0000000, bus.resetLine_n,
    bus.slave_present_activity_n, bus.diag_handshake_n,
    bus.word_width_ack_n, bus.host_interrupt_out};
  wire logic [31:0] readView =
    (avs_address == tfhp_pkg::AV_CTRL) ? 32'(ctrl_q) :
    (avs_address == tfhp_pkg::AV_RDATA) ? {16'h0000, rdData_q} :
    (avs_address == tfhp_pkg::AV_PINS) ? pinView : 32'h00000000;

  // A control write is held until its pin cycle reaches the hold phase,
  // so software never needs to poll for completion.
  assign avs_waitrequest = (ctrlWr && (st_q != HS_HOLD)) ||
                           (avs_read && !rdv_q);

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  assign bus.resetLine_n = rstDone_q;
  assign bus.register_index_lines =
    ctrl_q[tfhp_pkg::CTL_IDX_LSB +: 3];
  assign bus.low_select_n = !(active && !isHigh);
  assign bus.high_select_n = !(active && isHigh);
  assign bus.addrLatchEnable = (st_q == HS_SETUP);
  assign bus.write_strobe_n = !((st_q == HS_STROBE) && !isRead);
  assign bus.read_strobe_n = !((st_q == HS_STROBE) && isRead);
  assign bus.hostDataOut = ctrl_q[15:0];
  assign bus.hostOeLo_n = !(active && !isRead);
  assign bus.hostOeHi_n = !(active && !isRead && isWord);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rstCnt_q <= 5'h00;
      rstDone_q <= 1'b0;
    end else if (ce && !rstDone_q) begin
      rstCnt_q <= rstCnt_q + 5'h01;
      rstDone_q <= (rstCnt_q == 5'(tfhp_pkg::HOST_RST_HOLD_CYC - 1));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdv_q <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else if (ce) begin
      rdv_q <= avs_read && !rdv_q;
      if (avs_read && !rdv_q) begin
        avs_readdata <= readView;
      end
    end
  end

  // ----------------------------------------------------------------
  // Programmed I/O cycle
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q <= HS_IDLE;
      ctrl_q <= '0;
      pulse_q <= 4'h0;
      rdData_q <= 16'h0000;
    end else if (ce) begin
      case (st_q)
        HS_IDLE: begin
          if (ctrlWr && rstDone_q) begin
            ctrl_q <= avs_writedata[tfhp_pkg::CTL_W-1:0];
            st_q <= HS_SETUP;
          end
        end
        HS_SETUP: begin
          pulse_q <= 4'h0;
          st_q <= HS_STROBE;
        end
        HS_STROBE: begin
          if (isRead) begin
            rdData_q <= isWord ? bus.dataBus :
                        {8'h00, bus.dataBus[7:0]};
          end
          pulse_q <= pulse_q + 4'h1;
          if (pulse_q == 4'(tfhp_pkg::RW_PULSE_CYC - 1)) begin
            st_q <= HS_HOLD;
          end
        end
        HS_HOLD: st_q <= HS_IDLE;
        default: st_q <= HS_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// [sim/tfhp_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module tfhp_monitor (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic resetLine_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic [2:0] register_index_lines,
  input wire logic low_select_n,
  input wire logic high_select_n,
  input wire logic hostOeLo_n,
  input wire logic devOeLo_n,
  input wire logic devOeHi_n,
  input wire logic word_width_ack_n,
  input wire logic diag_handshake_n,
  input wire logic host_interrupt_out
);
  // ----------------------------------------------------------------
  // Pin relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire dataSel = !low_select_n && high_select_n &&
                 register_index_lines == tfhp_pkg::IDX_DATA;

  chk_bus_on_read: assert property (!devOeLo_n |-> !read_strobe_n)
    else $error("device drove bus outside a read");
  chk_upper_word: assert property (!devOeHi_n |-> dataSel && !devOeLo_n)
    else $error("upper byte driven off the data register");
  chk_no_clash: assert property (!(!devOeLo_n && !hostOeLo_n))
    else $error("host and device drove the bus together");
  chk_width_data: assert property (!word_width_ack_n |->
    dataSel || $past(dataSel))
    else $error("width indication without data register");
  chk_strobe_select: assert property (!write_strobe_n || !read_strobe_n |->
    low_select_n != high_select_n)
    else $error("strobe without exactly one select");
  chk_strobe_excl: assert property (!(!write_strobe_n && !read_strobe_n))
    else $error("read and write strobes low together");
  chk_diag_prompt: assert property (!resetLine_n ##1 !resetLine_n |->
    ##[0:2] !diag_handshake_n)
    else $error("slave did not assert handshake after reset");
  chk_reset_hold: assert property ($rose(rst_n) |-> !resetLine_n [*8])
    else $error("reset line released too early");

  cover property ($rose(write_strobe_n));
  cover property (!devOeHi_n);
  cover property ($rose(host_interrupt_out));
  cover property ($rose(diag_handshake_n));
endmodule
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  // Long counts are shortened so the run stays brief.
  localparam int POR_HOLD = 200;
  localparam int SRST_HOLD = 60;
  logic ref_clk, rst_n, ce, avsRead, avsWrite, avsWait, wrStb, cmdStb;
  logic [3:0] avsAddr;
  logic [31:0] avsWdata, avsRdata;
  logic driveReady, spinReady, diagRunning, diagPassed, irqSet, busy;
  logic wordReady, activity;
  logic [7:0] statusIn, errorIn, cmdByte;
  logic [15:0] rdWord, wrWord, lfsr;
  logic [7:0][7:0] taskFile;
  logic [63:0] note;
  logic [63:0] rdQ[$];
  logic [15:0] wordQ[$];
  logic [7:0] cmdQ[$];
  int errors, checks, cycles;

  tfhp_if tfIf ();
  tfhp_host tfhp_host_i (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
    .bus(tfIf), .avs_address(avsAddr), .avs_read(avsRead),
    .avs_write(avsWrite), .avs_writedata(avsWdata),
    .avs_readdata(avsRdata), .avs_waitrequest(avsWait));
  tfhp_drive #(.P_PRESENT_CHECK(20), .P_POR_SLV_HOLD(POR_HOLD),
    .P_POR_MST_WAIT(220), .P_SRST_SLV_HOLD(SRST_HOLD),
    .P_SRST_MST_WAIT(80), .P_SLV_PRESENT(400)) tfhp_drive_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .bus(tfIf), .isSlave(1'b1),
    .pinMode(tfhp_pkg::PM_ACTIVITY), .activity(activity),
    .spindleSync(1'b0), .spinReady(spinReady), .driveReady(driveReady),
    .diagRunning(diagRunning), .diagPassed(diagPassed),
    .statusIn(statusIn), .errorIn(errorIn), .irqSet(irqSet),
    .wordReady(wordReady), .rdWord(rdWord), .wrWord_q(wrWord),
    .wrWordStb_q(wrStb), .rdWordStb_q(), .cmdByte_q(cmdByte),
    .cmdStb_q(cmdStb), .taskFile_q(taskFile), .busy_q(busy), .slaveSeen_q());
  tfhp_monitor tfhp_monitor_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .resetLine_n(tfIf.resetLine_n), .write_strobe_n(tfIf.write_strobe_n),
    .read_strobe_n(tfIf.read_strobe_n),
    .register_index_lines(tfIf.register_index_lines),
    .low_select_n(tfIf.low_select_n), .high_select_n(tfIf.high_select_n),
    .hostOeLo_n(tfIf.hostOeLo_n), .devOeLo_n(tfIf.devOeLo_n),
    .devOeHi_n(tfIf.devOeHi_n), .word_width_ack_n(tfIf.word_width_ack_n),
    .diag_handshake_n(tfIf.diag_handshake_n),
    .host_interrupt_out(tfIf.host_interrupt_out));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic cmp_data(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_flag(input string nm, input logic e, g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  // The request is held until waitrequest is seen low.
  task automatic av(input logic [3:0] a, input logic wr,
                    input logic [31:0] d);
    @(posedge ref_clk);
    avsAddr <= a;
    avsRead <= !wr;
    avsWrite <= wr;
    avsWdata <= d;
    do begin
      @(posedge ref_clk);
    end while (avsWait !== 1'b0);
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask
  task automatic tf(input logic hi, rd, wd, input logic [2:0] idx,
                    input logic [15:0] d);
    av(tfhp_pkg::AV_CTRL, 1'b1, {10'h000, wd, rd, hi, idx, d});
  endtask
  task automatic rd_exp(input logic [3:0] a, input logic [31:0] e, m);
    rdQ.push_back({e, m});
    av(a, 1'b0, 32'h0);
  endtask
  task automatic wait_diag(input logic lvl, input int lim, output int n);
    n = 0;
    while (tfIf.diag_handshake_n !== lvl && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
  endtask
  task automatic irq_pulse();
    irqSet <= 1'b1;
    @(posedge ref_clk);
    irqSet <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Result watcher and timeout
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
    if (avsRead && avsWait === 1'b0) begin
      note = rdQ.size() > 0 ? rdQ.pop_front() : 64'h0;
      cmp_data("read", note[63:32] & note[31:0], avsRdata & note[31:0]);
    end
    if (wrStb === 1'b1)
      cmp_data("word", {16'h0, wordQ.pop_front()}, {16'h0, wrWord});
    if (cmdStb === 1'b1)
      cmp_data("cmd", {24'h0, cmdQ.pop_front()}, {24'h0, cmdByte});
  end

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    int n;
    logic [15:0] v;
    lfsr = 16'h004C;
    {errors, checks, cycles} = '0;
    {ce, rst_n, avsAddr, avsRead, avsWrite, avsWdata} = {1'b1, 39'h0};
    {driveReady, spinReady, diagRunning, diagPassed, irqSet} = '0;
    {wordReady, activity, statusIn, errorIn, rdWord} = '0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    wait_diag(1'b0, 5, n);
    cmp_flag("diag low", 1'b1, n < 5);
    wait_diag(1'b1, POR_HOLD + 60, n);
    cmp_flag("diag free", 1'b1, n >= POR_HOLD && n <= POR_HOLD + 40);
    tf(1'b0, 1'b0, 1'b0, tfhp_pkg::IDX_SDH, 16'h0015);
    tf(1'b1, 1'b0, 1'b0, tfhp_pkg::IDX_ALTDOR, 16'h0000);
    for (int i = 1; i < 6; i++) begin
      v = rnd();
      activity <= v[8];
      tf(1'b0, 1'b0, 1'b0, 3'(i), v);
      repeat (2) @(posedge ref_clk);
      cmp_data("task file", {24'h0, v[7:0]}, {24'h0, taskFile[i]});
    end
    v = rnd();
    errorIn <= v[7:0];
    statusIn <= v[15:8] & 8'h7F;
    tf(1'b0, 1'b1, 1'b0, tfhp_pkg::IDX_ERROR, 16'h0);
    rd_exp(tfhp_pkg::AV_RDATA, {24'h0, v[7:0]}, 32'hFFFF);
    tf(1'b0, 1'b1, 1'b0, tfhp_pkg::IDX_STATCMD, 16'h0);
    rd_exp(tfhp_pkg::AV_RDATA, {24'h0, v[15:8] & 8'h2F}, 32'hFF);
    spinReady <= 1'b1;
    tf(1'b0, 1'b1, 1'b0, tfhp_pkg::IDX_STATCMD, 16'h0);
    rd_exp(tfhp_pkg::AV_RDATA, {24'h0, v[15:8] & 8'h7F}, 32'hFF);
    v = rnd();
    rdWord <= v;
    wordReady <= 1'b1;
    tf(1'b0, 1'b1, 1'b1, tfhp_pkg::IDX_DATA, 16'h0);
    rd_exp(tfhp_pkg::AV_RDATA, {16'h0, v}, 32'hFFFF);
    v = rnd();
    wordQ.push_back(v);
    tf(1'b0, 1'b0, 1'b1, tfhp_pkg::IDX_DATA, v);
    irq_pulse();
    rd_exp(tfhp_pkg::AV_PINS, 32'h1, 32'h1);
    tf(1'b0, 1'b1, 1'b0, tfhp_pkg::IDX_STATCMD, 16'h0);
    rd_exp(tfhp_pkg::AV_PINS, 32'h0, 32'h1);
    irq_pulse();
    tf(1'b1, 1'b0, 1'b0, tfhp_pkg::IDX_ALTDOR, 16'h0002);
    rd_exp(tfhp_pkg::AV_PINS, 32'h0, 32'h1);
    tf(1'b1, 1'b0, 1'b0, tfhp_pkg::IDX_ALTDOR, 16'h0000);
    rd_exp(tfhp_pkg::AV_PINS, 32'h3, 32'hB);
    v = rnd();
    cmdQ.push_back(v[7:0]);
    tf(1'b0, 1'b0, 1'b0, tfhp_pkg::IDX_STATCMD, v);
    rd_exp(tfhp_pkg::AV_PINS, 32'h0, 32'h1);
    // Deselected: no bus drive, no interrupt, no command strobe.
    tf(1'b0, 1'b0, 1'b0, tfhp_pkg::IDX_SDH, 16'h0005);
    tf(1'b0, 1'b1, 1'b0, tfhp_pkg::IDX_STATCMD, 16'h0);
    rd_exp(tfhp_pkg::AV_RDATA, 32'hFF, 32'hFF);
    irq_pulse();
    rd_exp(tfhp_pkg::AV_PINS, 32'h0, 32'h1);
    tf(1'b0, 1'b0, 1'b0, tfhp_pkg::IDX_STATCMD, v);
    rd_exp(4'hC, 32'h0, 32'hFFFFFFFF);
    tf(1'b0, 1'b0, 1'b0, tfhp_pkg::IDX_SDH, 16'h0015);
    tf(1'b1, 1'b0, 1'b0, tfhp_pkg::IDX_ALTDOR, 16'h0004);
    wait_diag(1'b0, 10, n);
    cmp_flag("soft low", 1'b1, n < 10 && busy);
    tf(1'b1, 1'b0, 1'b0, tfhp_pkg::IDX_ALTDOR, 16'h0000);
    wait_diag(1'b1, SRST_HOLD + 20, n);
    cmp_flag("soft free", 1'b1, n >= 40 && n <= SRST_HOLD && !busy);
    diagPassed <= 1'b1;
    wait_diag(1'b0, 5, n);
    cmp_flag("diag pass", 1'b1, n < 5);
    diagRunning <= 1'b1;
    wait_diag(1'b1, 5, n);
    cmp_flag("diag run", 1'b1, n < 5);
    repeat (5) @(posedge ref_clk);
    cmp_flag("drained", 1'b1, rdQ.size() + wordQ.size() + cmdQ.size() == 0);
    print_verdict();
  end
endmodule
`default_nettype wire
